// ===== rtl/olsc_accel_if.sv
// olsc_accel_if: acceleration codes out to the lookup, rates back.
// assumes: both ends on the same clock, purely combinational path.
`timescale 1ns/100ps
interface olsc_accel_if;
   logic [4:0] a1_code;
   logic [4:0] a2_code;
   olsc_pkg::olsc_rate_t a1_rate;
   olsc_pkg::olsc_rate_t a2_rate;
   modport cfg (output a1_code, output a2_code, input a1_rate, input a2_rate);
   modport lut (input a1_code, input a2_code, output a1_rate, output a2_rate);
endinterface

// ===== rtl/olsc_accel_lut.sv
// olsc_accel_lut: maps both acceleration codes onto rates in milli units.
// assumes: codes come from registered configuration bits.
`timescale 1ns/100ps
module olsc_accel_lut (
   olsc_accel_if.lut acc
);
   import olsc_pkg::*;
   // =========================================
   // lookup
   always_comb begin
      acc.a1_rate = olsc_accel_rate(acc.a1_code);
      acc.a2_rate = olsc_accel_rate(acc.a2_code);
   end
endmodule // olsc_accel_lut

// ===== rtl/olsc_pkg.sv
// olsc_pkg: offsets, field layout, reset values, timing and code tables
// for the open-loop startup configuration register.
// assumes: a single 10 MHz device clock.
package olsc_pkg;
   // =========================================
   // register map
   localparam logic [7:0] OLSC_CFG_OFFSET = 8'h84;
   localparam logic [31:0] OLSC_CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] OLSC_CFG_WMASK = 32'hffff_e000;
   localparam int OLSC_PARITY_BIT = 31;
   localparam int OLSC_SRC_BIT = 30;
   localparam int OLSC_DUTY_HI = 29;
   localparam int OLSC_DUTY_LO = 27;
   localparam int OLSC_ILIM_HI = 26;
   localparam int OLSC_ILIM_LO = 23;
   localparam int OLSC_A1_HI = 22;
   localparam int OLSC_A1_LO = 18;
   localparam int OLSC_A2_HI = 17;
   localparam int OLSC_A2_LO = 13;
   // =========================================
   // timing
   localparam int OLSC_CLK_PERIOD_NS = 100;
   localparam int OLSC_TICK_NS = 1000000;
   localparam int OLSC_TICK_CYCLES = OLSC_TICK_NS / OLSC_CLK_PERIOD_NS;
   // =========================================
   // value widths and scaling
   localparam int OLSC_RATE_W = 25;
   localparam int OLSC_ACC_W = 40;
   localparam int OLSC_FREQ_W = 48;
   localparam logic [4:0] OLSC_CODE_UNLIMITED = 5'h1f;
   // 32767 Hz/s expressed in mHz/s
   localparam logic [24:0] OLSC_RATE_UNLIMITED = 25'h1f3_fc18;
   localparam logic [14:0] OLSC_MILLI = 15'h3e8;

   typedef logic [24:0] olsc_rate_t;

   // duty ceiling code to permille
   function automatic logic [9:0] olsc_duty_pm(input logic [2:0] code);
      unique case (code)
         3'h0: olsc_duty_pm = 10'h064;
         3'h1: olsc_duty_pm = 10'h096;
         3'h2: olsc_duty_pm = 10'h0c8;
         3'h3: olsc_duty_pm = 10'h0fa;
         3'h4: olsc_duty_pm = 10'h12c;
         3'h5: olsc_duty_pm = 10'h190;
         3'h6: olsc_duty_pm = 10'h1f4;
         3'h7: olsc_duty_pm = 10'h3e8;
      endcase
   endfunction

   // acceleration code to mHz/s (or mHz/s2), shared by both orders
   function automatic olsc_rate_t olsc_accel_rate(input logic [4:0] code);
      unique case (code)
         5'h00: olsc_accel_rate = 25'h000_0005;
         5'h01: olsc_accel_rate = 25'h000_000a;
         5'h02: olsc_accel_rate = 25'h000_0019;
         5'h03: olsc_accel_rate = 25'h000_0032;
         5'h04: olsc_accel_rate = 25'h000_0064;
         5'h05: olsc_accel_rate = 25'h000_00fa;
         5'h06: olsc_accel_rate = 25'h000_01f4;
         5'h07: olsc_accel_rate = 25'h000_03e8;
         5'h08: olsc_accel_rate = 25'h000_09c4;
         5'h09: olsc_accel_rate = 25'h000_1388;
         5'h0a: olsc_accel_rate = 25'h000_1d4c;
         5'h0b: olsc_accel_rate = 25'h000_2710;
         5'h0c: olsc_accel_rate = 25'h000_30d4;
         5'h0d: olsc_accel_rate = 25'h000_3a98;
         5'h0e: olsc_accel_rate = 25'h000_4e20;
         5'h0f: olsc_accel_rate = 25'h000_7530;
         5'h10: olsc_accel_rate = 25'h000_9c40;
         5'h11: olsc_accel_rate = 25'h000_c350;
         5'h12: olsc_accel_rate = 25'h000_ea60;
         5'h13: olsc_accel_rate = 25'h001_24f8;
         5'h14: olsc_accel_rate = 25'h001_86a0;
         5'h15: olsc_accel_rate = 25'h001_e848;
         5'h16: olsc_accel_rate = 25'h002_49f0;
         5'h17: olsc_accel_rate = 25'h002_ab98;
         5'h18: olsc_accel_rate = 25'h003_0d40;
         5'h19: olsc_accel_rate = 25'h003_d090;
         5'h1a: olsc_accel_rate = 25'h004_93e0;
         5'h1b: olsc_accel_rate = 25'h006_1a80;
         5'h1c: olsc_accel_rate = 25'h007_a120;
         5'h1d: olsc_accel_rate = 25'h00b_71b0;
         5'h1e: olsc_accel_rate = 25'h00f_4240;
         5'h1f: olsc_accel_rate = OLSC_RATE_UNLIMITED;
      endcase
   endfunction
endpackage

// ===== rtl/olsc_top.sv
// olsc_top: open-loop startup configuration register, duty ceiling,
// current-limit source select and open-loop frequency ramp.
// assumes: register strobes and control inputs are on clk, host serial
// front end decodes frames into single-cycle word accesses.
`timescale 1ns/100ps
module olsc_top #(
   parameter int TICK_CYCLES = olsc_pkg::OLSC_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [3:0] general_current_limit,
   input wire logic openloop_active,
   input wire logic [9:0] duty_request,
   output logic [9:0] duty_cmd,
   output logic [9:0] duty_ceiling_pm,
   output logic [3:0] ol_current_limit,
   output logic ol_limit_reserved,
   output olsc_pkg::olsc_rate_t accel_first_rate,
   output olsc_pkg::olsc_rate_t accel_second_rate,
   output logic [47:0] ramp_freq_nhz
);
   import olsc_pkg::*;

   if (TICK_CYCLES < 2) begin : g_chk
      $error("TICK_CYCLES must be at least 2");
   end

   localparam int TW = $clog2(TICK_CYCLES);

   logic [31:0] cfg_reg;
   logic [TW-1:0] tick_cnt_reg;
   logic tick;
   logic [OLSC_ACC_W-1:0] rate2_reg;
   logic [OLSC_ACC_W-1:0] rate_sum;
   logic [OLSC_FREQ_W-1:0] freq_reg;
   logic sel_wr;
   olsc_accel_if acc ();

   // =========================================
   // register access
   assign sel_wr = reg_wr && (reg_addr == OLSC_CFG_OFFSET);
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cfg_reg <= OLSC_CFG_RESET;
      end else if (sel_wr) begin
         // low bits belong to other logic and stay zero here
         cfg_reg <= reg_wdata & OLSC_CFG_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rvalid <= 1'b0;
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rvalid <= reg_rd;
         // unmapped offsets read zero
         reg_rdata <= (reg_rd && reg_addr == OLSC_CFG_OFFSET) ? cfg_reg : 32'h0000_0000;
      end
   end

   // =========================================
   // decoded settings
   assign acc.a1_code = cfg_reg[OLSC_A1_HI:OLSC_A1_LO];
   assign acc.a2_code = cfg_reg[OLSC_A2_HI:OLSC_A2_LO];
   olsc_accel_lut u_lut (
      .acc(acc)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         duty_ceiling_pm <= 10'h000;
         duty_cmd <= 10'h000;
         ol_current_limit <= 4'h0;
         ol_limit_reserved <= 1'b0;
         accel_first_rate <= 25'h000_0000;
         accel_second_rate <= 25'h000_0000;
      end else begin
         duty_ceiling_pm <= olsc_duty_pm(cfg_reg[OLSC_DUTY_HI:OLSC_DUTY_LO]);
         // clamp against the live field so a lowered ceiling acts at once
         if (duty_request > olsc_duty_pm(cfg_reg[OLSC_DUTY_HI:OLSC_DUTY_LO])) begin
            duty_cmd <= olsc_duty_pm(cfg_reg[OLSC_DUTY_HI:OLSC_DUTY_LO]);
         end else begin
            duty_cmd <= duty_request;
         end
         if (cfg_reg[OLSC_SRC_BIT]) begin
            ol_current_limit <= general_current_limit;
         end else begin
            ol_current_limit <= cfg_reg[OLSC_ILIM_HI:OLSC_ILIM_LO];
         end
         // code 0 is reserved; flagged, not remapped
         ol_limit_reserved <= !cfg_reg[OLSC_SRC_BIT]
            && cfg_reg[OLSC_ILIM_HI:OLSC_ILIM_LO] == 4'h0;
         accel_first_rate <= acc.a1_rate;
         accel_second_rate <= acc.a2_rate;
      end
   end

   // =========================================
   // open-loop ramp, updated once per 1 ms tick
   assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
   always_ff @(posedge clk) begin
      if (!rst_b || !openloop_active || tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 1'b1;
      end
   end

   // rates in uHz/s: first order scaled by 1000, second order integrated
   assign rate_sum = OLSC_ACC_W'(acc.a1_rate * OLSC_MILLI) + rate2_reg;
   always_ff @(posedge clk) begin
      if (!rst_b || !openloop_active) begin
         rate2_reg <= '0;
      end else if (tick) begin
         rate2_reg <= rate2_reg + OLSC_ACC_W'(acc.a2_rate);
      end
   end

   // no saturation: 48 bits of nHz outlast any real startup
   always_ff @(posedge clk) begin
      if (!rst_b || !openloop_active) begin
         freq_reg <= '0;
      end else if (tick) begin
         freq_reg <= freq_reg + OLSC_FREQ_W'(rate_sum);
      end
   end
   assign ramp_freq_nhz = freq_reg;

   // =========================================
   // checks
   property p_reset_zero;
      @(posedge clk) !rst_b |=> cfg_reg == OLSC_CFG_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("cfg not zero after reset");

   property p_write_store;
      @(posedge clk) disable iff (!rst_b)
         sel_wr |=> cfg_reg[31:13] == $past(reg_wdata[31:13]) && cfg_reg[12:0] == 13'h0000;
   endproperty
   a_write_store: assert property (p_write_store) else $error("write not stored");

   property p_read_back;
      @(posedge clk) disable iff (!rst_b)
         reg_rd && reg_addr == OLSC_CFG_OFFSET && !reg_wr |=> reg_rvalid && reg_rdata == cfg_reg;
   endproperty
   a_read_back: assert property (p_read_back) else $error("read data mismatch");

   property p_duty_cap;
      @(posedge clk) disable iff (!rst_b)
         ##1 $stable(cfg_reg) |-> duty_cmd <= duty_ceiling_pm;
   endproperty
   a_duty_cap: assert property (p_duty_cap) else $error("duty above ceiling");

   property p_duty_full;
      @(posedge clk) disable iff (!rst_b)
         cfg_reg[OLSC_DUTY_HI:OLSC_DUTY_LO] == 3'h7 |=> duty_ceiling_pm == 10'h3e8;
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("100 percent ceiling wrong");

   property p_src_general;
      @(posedge clk) disable iff (!rst_b)
         cfg_reg[OLSC_SRC_BIT] |=> ol_current_limit == $past(general_current_limit);
   endproperty
   a_src_general: assert property (p_src_general) else $error("limit source wrong");

   property p_src_field;
      @(posedge clk) disable iff (!rst_b)
         !cfg_reg[OLSC_SRC_BIT] |=> ol_current_limit == $past(cfg_reg[OLSC_ILIM_HI:OLSC_ILIM_LO]);
   endproperty
   a_src_field: assert property (p_src_field) else $error("field limit wrong");

   property p_unlimited;
      @(posedge clk) disable iff (!rst_b)
         cfg_reg[OLSC_A1_HI:OLSC_A1_LO] == OLSC_CODE_UNLIMITED
         |=> accel_first_rate == 25'h1f3_fc18;
   endproperty
   a_unlimited: assert property (p_unlimited) else $error("unlimited rate wrong");

   property p_ramp_min;
      @(posedge clk) disable iff (!rst_b)
         tick && openloop_active && $stable(cfg_reg)
         |=> freq_reg >= $past(freq_reg) + OLSC_FREQ_W'(accel_first_rate) * 1000;
   endproperty
   a_ramp_min: assert property (p_ramp_min) else $error("ramp too slow");

   property p_ramp_hold;
      @(posedge clk) disable iff (!rst_b)
         openloop_active && !tick |=> freq_reg == $past(freq_reg);
   endproperty
   a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved off tick");

   property p_ramp_idle;
      @(posedge clk) disable iff (!rst_b)
         !openloop_active |=> freq_reg == '0 && rate2_reg == '0;
   endproperty
   a_ramp_idle: assert property (p_ramp_idle) else $error("ramp not cleared");

   c_write: cover property (@(posedge clk) disable iff (!rst_b) sel_wr ##2 reg_rd);
   c_clamp: cover property (@(posedge clk) disable iff (!rst_b)
      duty_request > duty_ceiling_pm);
   c_general: cover property (@(posedge clk) disable iff (!rst_b) cfg_reg[OLSC_SRC_BIT]);
   c_ramp: cover property (@(posedge clk) disable iff (!rst_b)
      openloop_active && tick ##1 freq_reg != '0);
endmodule // olsc_top

// ===== test/olsc_top_tb.sv
// olsc_top_tb: self-checking bench for the open-loop startup config register.
// assumes: olsc_pkg and olsc_top compiled first; word strobe register port on clk.
`timescale 1ns/100ps
module olsc_top_tb;
   import olsc_pkg::*;
   // =========================================
   // signals
   // short tick so the ramp shows up within a few cycles
   localparam int TICKS = 4;
   localparam logic [7:0] BAD_ADDR = 8'h88;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [3:0] general_current_limit = 4'h0;
   logic openloop_active = 1'b0;
   logic [9:0] duty_request = 10'h000;
   logic [31:0] reg_rdata;
   logic reg_rvalid;
   logic [9:0] duty_cmd;
   logic [9:0] duty_ceiling_pm;
   logic [3:0] ol_current_limit;
   logic ol_limit_reserved;
   olsc_rate_t accel_first_rate;
   olsc_rate_t accel_second_rate;
   logic [47:0] ramp_freq_nhz;
   int miscompares = 0;
   int total_checks = 0;
   // own copies of the ladders, so a wrong design table cannot hide
   int duty_tbl [8] = '{100, 150, 200, 250, 300, 400, 500, 1000};
   int acc_tbl [32] = '{5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000, 7500, 10000, 12500,
      15000, 20000, 30000, 40000, 50000, 60000, 75000, 100000, 125000, 150000, 175000,
      200000, 250000, 300000, 400000, 500000, 750000, 1000000, 32767000};

   always #(OLSC_CLK_PERIOD_NS / 2) clk = ~clk;

   olsc_top #(.TICK_CYCLES(TICKS)) DUT (
      .clk(clk),
      .rst_b(rst_b),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid),
      .general_current_limit(general_current_limit),
      .openloop_active(openloop_active),
      .duty_request(duty_request),
      .duty_cmd(duty_cmd),
      .duty_ceiling_pm(duty_ceiling_pm),
      .ol_current_limit(ol_current_limit),
      .ol_limit_reserved(ol_limit_reserved),
      .accel_first_rate(accel_first_rate),
      .accel_second_rate(accel_second_rate),
      .ramp_freq_nhz(ramp_freq_nhz)
   );

   // =========================================
   // compare, access and closing tasks
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t read got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_out(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t output got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_out(48'(reg_rvalid), 48'h1);
      chk_rd(reg_rdata, exp);
   endtask

   // decoded outputs trail the register by one cycle
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
   endtask

   task automatic complete_run();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // =========================================
   // tests
   initial begin
      do_reset();
      rd_check(OLSC_CFG_OFFSET, 32'h0000_0000);
      chk_out(48'(duty_ceiling_pm), 48'h64);
      chk_out(48'(accel_first_rate), 48'h5);
      chk_out(48'(accel_second_rate), 48'h5);
      chk_out(48'(ol_limit_reserved), 48'h1);
      $display("test reset_values done");
      wr(OLSC_CFG_OFFSET, 32'hffff_ffff);
      rd_check(OLSC_CFG_OFFSET, 32'hffff_e000);
      wr(BAD_ADDR, 32'h0000_0000);
      rd_check(OLSC_CFG_OFFSET, 32'hffff_e000);
      rd_check(BAD_ADDR, 32'h0000_0000);
      wr(OLSC_CFG_OFFSET, 32'h7fff_ffff);
      rd_check(OLSC_CFG_OFFSET, 32'h7fff_e000);
      wr(OLSC_CFG_OFFSET, 32'h8000_0000);
      rd_check(OLSC_CFG_OFFSET, 32'h8000_0000);
      wr(OLSC_CFG_OFFSET, 32'hffff_ffff);
      do_reset();
      rd_check(OLSC_CFG_OFFSET, 32'h0000_0000);
      $display("test register_access done");
      for (int c = 0; c < 8; c++) begin
         @(posedge clk);
         duty_request <= 10'h3ff;
         wr(OLSC_CFG_OFFSET, 32'(c) << OLSC_DUTY_LO);
         settle();
         chk_out(48'(duty_ceiling_pm), 48'(duty_tbl[c]));
         chk_out(48'(duty_cmd), 48'(duty_tbl[c]));
         @(posedge clk);
         duty_request <= 10'h078;
         settle();
         chk_out(48'(duty_cmd), (duty_tbl[c] < 120) ? 48'(duty_tbl[c]) : 48'h78);
      end
      $display("test duty_ceiling done");
      for (int c = 0; c < 32; c++) begin
         wr(OLSC_CFG_OFFSET, (32'(c) << OLSC_A1_LO) | (32'(31 - c) << OLSC_A2_LO));
         settle();
         chk_out(48'(accel_first_rate), 48'(acc_tbl[c]));
         chk_out(48'(accel_second_rate), 48'(acc_tbl[31 - c]));
      end
      $display("test accel_codes done");
      @(posedge clk);
      general_current_limit <= 4'h9;
      for (int c = 0; c < 32; c++) begin
         wr(OLSC_CFG_OFFSET, (32'(c[4]) << OLSC_SRC_BIT) | (32'(c[3:0]) << OLSC_ILIM_LO));
         settle();
         chk_out(48'(ol_current_limit), c[4] ? 48'h9 : 48'(c[3:0]));
         chk_out(48'(ol_limit_reserved), 48'(c == 0));
      end
      @(posedge clk);
      general_current_limit <= 4'h3;
      settle();
      chk_out(48'(ol_current_limit), 48'h3);
      $display("test current_limit done");
      wr(OLSC_CFG_OFFSET, (32'h7 << OLSC_A1_LO) | (32'h7 << OLSC_A2_LO));
      @(posedge clk);
      openloop_active <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_out(ramp_freq_nhz, 48'h0);
      settle();
      chk_out(ramp_freq_nhz, 48'h0f_4240);
      repeat (4) @(posedge clk);
      #1;
      chk_out(ramp_freq_nhz, 48'h1e_8868);
      @(posedge clk);
      openloop_active <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk_out(ramp_freq_nhz, 48'h0);
      $display("test ramp done");
      complete_run();
   end

   // generous bound: the tests need well under a thousand cycles
   initial begin
      #(OLSC_CLK_PERIOD_NS * 5000);
      miscompares++;
      complete_run();
   end
endmodule // olsc_top_tb
